// *** shared/fsli_pkg.sv ***
// constants, register map and pattern codes of the fieldbus indicator block
package fsli_pkg;
   // ---------------------------------------------------------------
   // timebase
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned FLICK_HALF_MS = 50;
   localparam int unsigned TICK_CYC_DEF = FLICK_HALF_MS * (CLK_HZ / 1000);
   localparam int TB_W = 20;
   localparam logic [1:0] TICKS_PER_SLOT_M1 = 2'h3;
   localparam logic [3:0] SLOT_LAST = 4'h9;
   localparam logic [3:0] FLASH_A = 4'h0;
   localparam logic [3:0] FLASH_B = 4'h2;
   localparam logic [3:0] FLASH_C = 4'h4;
   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam int AW = 5;
   localparam logic [4:0] OFS_CTRL = 5'h00;
   localparam logic [4:0] OFS_AL = 5'h04;
   localparam logic [4:0] OFS_HOLD = 5'h08;
   localparam logic [4:0] OFS_ERRC = 5'h0C;
   localparam logic [4:0] OFS_STAT = 5'h10;
   localparam logic [4:0] OFS_ISTAT = 5'h14;
   localparam logic [4:0] OFS_IMASK = 5'h18;
   localparam logic [4:0] OFS_ROT = 5'h1C;
   localparam int CTRL_ERR_EN = 0;
   localparam int CTRL_OPT_EN = 1;
   localparam int CTRL_IDENT = 2;
   localparam logic [3:0] CTRL_RST = 4'h2;
   localparam logic [3:0] AL_INIT = 4'h1;
   localparam logic [3:0] AL_PREOP = 4'h2;
   localparam logic [3:0] AL_BOOT = 4'h3;
   localparam logic [3:0] AL_SAFEOP = 4'h4;
   localparam logic [3:0] AL_OP = 4'h8;
   localparam int ERR_WDOG = 0;
   localparam int ERR_LOCAL = 1;
   localparam int ERR_CONFIG = 2;
   localparam int ERR_BOOT = 3;
   localparam int IRQ_LINK = 0;
   localparam int IRQ_ANEG = 2;
   localparam int STAT_LINK = 0;
   localparam int STAT_LAMP = 2;
   localparam int STAT_RUN = 4;
   localparam int STAT_ERR = 5;
   localparam int STAT_BOOT = 6;
   localparam logic [7:0] FAULT_CODE = 8'h11;
   // ---------------------------------------------------------------
   // ports and synchronised pin vector layout
   // ---------------------------------------------------------------
   localparam int NPORTS = 2;
   localparam int PORT_UP = 0;
   localparam int PORT_DOWN = 1;
   localparam int PIN_LINK = 0;
   localparam int PIN_ACT = 2;
   localparam int PIN_ANL = 4;
   localparam int PIN_ANR = 6;
   localparam int PIN_ANU = 8;
   localparam int PIN_ROT = 10;
   localparam int PIN_W = 14;
   typedef enum logic [7:0] {
      PAT_OFF = 8'h01,
      PAT_ON = 8'h02,
      PAT_FLICK = 8'h04,
      PAT_BLINK = 8'h08,
      PAT_SINGLE = 8'h10,
      PAT_DOUBLE = 8'h20,
      PAT_TRIPLE = 8'h40,
      PAT_INVDBL = 8'h80
   } fsli_pat_t;
endpackage : fsli_pkg

// *** src/fsli_top.sv ***
// fieldbus status lamp indicator with avalon register slave
//
// The Avalon-MM slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module fsli_top #(
   parameter int unsigned TICK_CYC = fsli_pkg::TICK_CYC_DEF
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [4:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic upstream_port_link_i,
   input wire logic upstream_port_act_i,
   input wire logic upstream_port_aneg_local_i,
   input wire logic upstream_port_aneg_remote_i,
   input wire logic upstream_port_aneg_unknown_i,
   input wire logic downstream_port_link_i,
   input wire logic downstream_port_act_i,
   input wire logic downstream_port_aneg_local_i,
   input wire logic downstream_port_aneg_remote_i,
   input wire logic downstream_port_aneg_unknown_i,
   input wire logic [3:0] rotary_switch_i,
   output logic [1:0] port_link_activity_lamp_o,
   output logic run_lamp_o,
   output logic error_lamp_o,
   output logic fieldbus_fault_o,
   output logic [7:0] fieldbus_fault_display_code_o,
   output logic irq_o
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic [3:0] ctrl;
      logic [3:0] al;
      logic boot;
      logic [1:0] hold;
      logic [3:0] errc;
      logic [3:0] istat;
      logic [3:0] imask;
      logic [13:0] sy1;
      logic [13:0] sy2;
      logic [1:0] link_d;
      logic [1:0] aneg_d;
      logic [1:0] act_seen;
      logic [1:0] act_win;
      logic [19:0] tb;
      logic [1:0] sub;
      logic flick;
      logic blink;
      logic [3:0] slot;
      logic [1:0] plamp;
      logic run;
      logic err;
      logic fault;
      logic [7:0] code;
   } fsli_st_t;

   localparam fsli_st_t ST_RST = '{ctrl: fsli_pkg::CTRL_RST,
                                   boot: 1'b1, default: '0};
   localparam logic [19:0] TICK_LAST = 20'(TICK_CYC - 1);

   fsli_st_t s_r;
   fsli_st_t s_nxt;
   logic [13:0] pins;
   logic [1:0] lnk;
   logic [1:0] act;
   logic [1:0] anl;
   logic [1:0] anr;
   logic [1:0] anu;
   logic [3:0] rot;
   logic tick;
   logic in_init;
   logic [4:0] req_adr;
   logic wr_ok;
   logic [31:0] rd_val;
   fsli_pkg::fsli_pat_t pcode [2];
   fsli_pkg::fsli_pat_t rcode;
   fsli_pkg::fsli_pat_t ecode;

   // ---------------------------------------------------------------
   // pattern generator
   // ---------------------------------------------------------------
   function automatic logic pat_out(input fsli_pkg::fsli_pat_t c,
                                    input logic fl,
                                    input logic bl,
                                    input logic [3:0] sl);
      logic one;
      logic two;
      logic three;
      one = (sl == fsli_pkg::FLASH_A);
      two = one | (sl == fsli_pkg::FLASH_B);
      three = two | (sl == fsli_pkg::FLASH_C);
      case (c)
         fsli_pkg::PAT_OFF: pat_out = 1'b0;
         fsli_pkg::PAT_ON: pat_out = 1'b1;
         fsli_pkg::PAT_FLICK: pat_out = fl;
         fsli_pkg::PAT_BLINK: pat_out = bl;
         fsli_pkg::PAT_SINGLE: pat_out = one;
         fsli_pkg::PAT_DOUBLE: pat_out = two;
         fsli_pkg::PAT_TRIPLE: pat_out = three;
         fsli_pkg::PAT_INVDBL: pat_out = ~two;
         default: pat_out = 1'b0;
      endcase
   endfunction : pat_out

   // ---------------------------------------------------------------
   // pin mapping and decode
   // ---------------------------------------------------------------
   // upstream connector is index zero, downstream index one
   assign pins = {rotary_switch_i,
                  downstream_port_aneg_unknown_i,
                  upstream_port_aneg_unknown_i,
                  downstream_port_aneg_remote_i,
                  upstream_port_aneg_remote_i,
                  downstream_port_aneg_local_i,
                  upstream_port_aneg_local_i,
                  downstream_port_act_i,
                  upstream_port_act_i,
                  downstream_port_link_i,
                  upstream_port_link_i};
   assign lnk = s_r.sy2[fsli_pkg::PIN_LINK +: 2];
   assign act = s_r.sy2[fsli_pkg::PIN_ACT +: 2];
   assign anl = s_r.sy2[fsli_pkg::PIN_ANL +: 2];
   assign anr = s_r.sy2[fsli_pkg::PIN_ANR +: 2];
   assign anu = s_r.sy2[fsli_pkg::PIN_ANU +: 2];
   assign rot = s_r.sy2[fsli_pkg::PIN_ROT +: 4];
   assign tick = (s_r.tb == TICK_LAST);
   assign in_init = (s_r.al == fsli_pkg::AL_INIT) && !s_r.boot;
   assign req_adr = avs_address_i;
   assign wr_ok = avs_write_i && s_r.ack && avs_byteenable_i[0];

   // ---------------------------------------------------------------
   // lamp selection
   // ---------------------------------------------------------------
   always_comb begin
      for (int p = 0; p < fsli_pkg::NPORTS; p++) begin
         if (lnk[p]) begin
            if (s_r.hold[p]) begin
               pcode[p] = s_r.ctrl[fsli_pkg::CTRL_OPT_EN] ?
                          fsli_pkg::PAT_INVDBL : fsli_pkg::PAT_OFF;
            end else if (s_r.act_seen[p]) begin
               pcode[p] = fsli_pkg::PAT_FLICK;
            end else begin
               pcode[p] = fsli_pkg::PAT_ON;
            end
         end else if (!s_r.ctrl[fsli_pkg::CTRL_OPT_EN]) begin
            pcode[p] = fsli_pkg::PAT_OFF;
         end else if (anl[p]) begin
            pcode[p] = fsli_pkg::PAT_SINGLE;
         end else if (anr[p]) begin
            pcode[p] = fsli_pkg::PAT_DOUBLE;
         end else if (anu[p]) begin
            pcode[p] = fsli_pkg::PAT_TRIPLE;
         end else begin
            pcode[p] = fsli_pkg::PAT_OFF;
         end
      end
   end

   always_comb begin
      if (s_r.ctrl[fsli_pkg::CTRL_IDENT]) begin
         rcode = fsli_pkg::PAT_TRIPLE;
      end else if (s_r.boot || s_r.al == fsli_pkg::AL_BOOT) begin
         rcode = s_r.ctrl[fsli_pkg::CTRL_OPT_EN] ?
                 fsli_pkg::PAT_FLICK : fsli_pkg::PAT_OFF;
      end else begin
         case (s_r.al)
            fsli_pkg::AL_INIT: rcode = fsli_pkg::PAT_OFF;
            fsli_pkg::AL_PREOP: rcode = fsli_pkg::PAT_BLINK;
            fsli_pkg::AL_SAFEOP: rcode = fsli_pkg::PAT_SINGLE;
            fsli_pkg::AL_OP: rcode = fsli_pkg::PAT_ON;
            default: rcode = fsli_pkg::PAT_OFF;
         endcase
      end
   end

   // lamp stays dark unless software explicitly enables it
   always_comb begin
      if (!s_r.ctrl[fsli_pkg::CTRL_ERR_EN]) begin
         ecode = fsli_pkg::PAT_OFF;
      end else if (s_r.errc[fsli_pkg::ERR_WDOG]) begin
         ecode = fsli_pkg::PAT_DOUBLE;
      end else if (s_r.errc[fsli_pkg::ERR_LOCAL]) begin
         ecode = fsli_pkg::PAT_SINGLE;
      end else if (s_r.errc[fsli_pkg::ERR_CONFIG]) begin
         ecode = fsli_pkg::PAT_BLINK;
      end else if (s_r.errc[fsli_pkg::ERR_BOOT] && in_init &&
                   s_r.ctrl[fsli_pkg::CTRL_OPT_EN]) begin
         ecode = fsli_pkg::PAT_FLICK;
      end else begin
         ecode = fsli_pkg::PAT_OFF;
      end
   end

   // ---------------------------------------------------------------
   // register read mux
   // ---------------------------------------------------------------
   always_comb begin
      rd_val = '0;
      case (req_adr)
         fsli_pkg::OFS_CTRL: rd_val[3:0] = s_r.ctrl;
         fsli_pkg::OFS_AL: rd_val[3:0] = s_r.al;
         fsli_pkg::OFS_HOLD: rd_val[1:0] = s_r.hold;
         fsli_pkg::OFS_ERRC: rd_val[3:0] = s_r.errc;
         fsli_pkg::OFS_STAT: begin
            rd_val[fsli_pkg::STAT_LINK +: 2] = lnk;
            rd_val[fsli_pkg::STAT_LAMP +: 2] = s_r.plamp;
            rd_val[fsli_pkg::STAT_RUN] = s_r.run;
            rd_val[fsli_pkg::STAT_ERR] = s_r.err;
            rd_val[fsli_pkg::STAT_BOOT] = s_r.boot;
         end
         fsli_pkg::OFS_ISTAT: rd_val[3:0] = s_r.istat;
         fsli_pkg::OFS_IMASK: rd_val[3:0] = s_r.imask;
         // switch id is only exposed while in init
         fsli_pkg::OFS_ROT: rd_val[3:0] = in_init ? rot : 4'h0;
         default: rd_val = '0;
      endcase
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.sy1 = pins;
      s_nxt.sy2 = s_r.sy1;
      // bus: one wait cycle, then answer
      s_nxt.ack = (avs_read_i || avs_write_i) && !s_r.ack;
      if (avs_read_i && !s_r.ack) begin
         s_nxt.rdata = rd_val;
      end
      if (wr_ok) begin
         case (req_adr)
            fsli_pkg::OFS_CTRL: s_nxt.ctrl = avs_writedata_i[3:0];
            fsli_pkg::OFS_AL: begin
               s_nxt.al = avs_writedata_i[3:0];
               s_nxt.boot = 1'b0;
            end
            fsli_pkg::OFS_HOLD: s_nxt.hold = avs_writedata_i[1:0];
            fsli_pkg::OFS_ERRC: s_nxt.errc = avs_writedata_i[3:0];
            fsli_pkg::OFS_ISTAT: begin
               s_nxt.istat = s_r.istat & ~avs_writedata_i[3:0];
            end
            fsli_pkg::OFS_IMASK: s_nxt.imask = avs_writedata_i[3:0];
            default: ;
         endcase
      end
      // events set after the clear so that the set wins
      s_nxt.link_d = lnk;
      s_nxt.aneg_d = anl | anr | anu;
      s_nxt.istat[fsli_pkg::IRQ_LINK +: 2] =
         s_nxt.istat[fsli_pkg::IRQ_LINK +: 2] | (lnk ^ s_r.link_d);
      s_nxt.istat[fsli_pkg::IRQ_ANEG +: 2] =
         s_nxt.istat[fsli_pkg::IRQ_ANEG +: 2] |
         (s_nxt.aneg_d & ~s_r.aneg_d);
      // shared timebase
      s_nxt.tb = tick ? '0 : s_r.tb + 20'h00001;
      // latch a whole tick window so that a quiet sample at the tick does
      // not drop a busy port back to steady for a cycle
      s_nxt.act_win = tick ? 2'h0 : (s_r.act_win | act);
      s_nxt.act_seen = tick ? (s_r.act_win | act) : s_r.act_seen;
      if (tick) begin
         s_nxt.flick = ~s_r.flick;
         s_nxt.sub = s_r.sub + 2'h1;
         if (s_r.sub == fsli_pkg::TICKS_PER_SLOT_M1) begin
            s_nxt.blink = ~s_r.blink;
            s_nxt.slot = (s_r.slot == fsli_pkg::SLOT_LAST) ?
                         4'h0 : s_r.slot + 4'h1;
         end
      end
      for (int p = 0; p < fsli_pkg::NPORTS; p++) begin
         s_nxt.plamp[p] = pat_out(pcode[p], s_r.flick, s_r.blink,
                                  s_r.slot);
      end
      s_nxt.run = pat_out(rcode, s_r.flick, s_r.blink, s_r.slot);
      s_nxt.err = pat_out(ecode, s_r.flick, s_r.blink, s_r.slot);
      s_nxt.fault = |s_r.errc;
      s_nxt.code = (|s_r.errc) ? fsli_pkg::FAULT_CODE : 8'h00;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_r <= ST_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign avs_readdata_o = s_r.rdata;
   assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !s_r.ack;
   assign port_link_activity_lamp_o = s_r.plamp;
   assign run_lamp_o = s_r.run;
   assign error_lamp_o = s_r.err;
   assign fieldbus_fault_o = s_r.fault;
   assign fieldbus_fault_display_code_o = s_r.code;
   assign irq_o = |(s_r.istat & s_r.imask);

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_run_sel(logic [3:0] st);
      !s_r.ctrl[fsli_pkg::CTRL_IDENT] && !s_r.boot && s_r.al == st;
   endsequence
   sequence s_rd_rot;
      avs_read_i && !avs_waitrequest_o &&
      avs_address_i == fsli_pkg::OFS_ROT;
   endsequence

   chk_link_dark: assert property (!lnk[0] && !anl[0] && !anr[0] &&
      !anu[0] |=> !port_link_activity_lamp_o[0])
      else $error("port lamp lit without link");
   chk_link_steady: assert property (lnk[1] && !s_r.hold[1] &&
      !s_r.act_seen[1] |=> port_link_activity_lamp_o[1])
      else $error("idle linked port lamp not on");
   chk_aneg_local: assert property (!lnk[0] && anl[0] &&
      s_r.ctrl[fsli_pkg::CTRL_OPT_EN] && s_r.slot == 4'h1
      |=> !port_link_activity_lamp_o[0])
      else $error("single flash lit in gap");
   chk_run_op: assert property (s_run_sel(fsli_pkg::AL_OP)
      |=> run_lamp_o)
      else $error("run lamp dark in operational");
   chk_run_init: assert property (s_run_sel(fsli_pkg::AL_INIT)
      |=> !run_lamp_o)
      else $error("run lamp lit in init");
   chk_run_safeop: assert property (s_run_sel(fsli_pkg::AL_SAFEOP) and
      s_r.slot == fsli_pkg::FLASH_B |=> !run_lamp_o)
      else $error("safe-op shows more than one flash");
   chk_run_ident: assert property (s_r.ctrl[fsli_pkg::CTRL_IDENT] &&
      s_r.slot == fsli_pkg::FLASH_C |=> run_lamp_o)
      else $error("identify third flash missing");
   chk_rot_gate: assert property (s_rd_rot and !in_init
      |-> avs_readdata_o == 32'h00000000)
      else $error("rotary id visible outside init");
   chk_err_unused: assert property (!s_r.ctrl[fsli_pkg::CTRL_ERR_EN]
      [*2] |-> !error_lamp_o)
      else $error("error lamp lit while unused");
   chk_fault_code: assert property ((|s_r.errc) |=>
      fieldbus_fault_o &&
      fieldbus_fault_display_code_o == fsli_pkg::FAULT_CODE)
      else $error("fault code not forwarded");
   chk_err_wdog: assert property (s_r.ctrl[fsli_pkg::CTRL_ERR_EN] &&
      s_r.errc[fsli_pkg::ERR_WDOG] && s_r.slot == fsli_pkg::FLASH_B
      |=> error_lamp_o)
      else $error("watchdog double flash missing");
   chk_flick_step: assert property (tick |=> s_r.flick !=
      $past(s_r.flick) && s_r.tb == 20'h00000)
      else $error("flicker did not step on tick");
   chk_bus_wait: assert property ((avs_read_i || avs_write_i) &&
      avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("bus answer later than one wait cycle");
endmodule : fsli_top
`default_nettype wire

// *** testbench/fsli_phy_model.sv ***
// behavioural model of one port's physical layer feeding the lamp logic
`timescale 1ns/1ns
`default_nettype none
module fsli_phy_model (
   input wire logic clk_i,
   input wire logic link_req_i,
   input wire logic traffic_i,
   input wire logic [1:0] aneg_i,
   output logic link_o,
   output logic act_o,
   output logic an_local_o,
   output logic an_remote_o,
   output logic an_unknown_o
);
   // ---------------------------------------------------------------
   // pin levels
   // ---------------------------------------------------------------
   logic act_r = 1'b0;
   // activity pulses every other cycle, so each tick window sees some
   always @(posedge clk_i) begin
      act_r <= traffic_i & link_req_i & ~act_r;
   end
   assign link_o = link_req_i;
   assign act_o = act_r;
   // negotiation failure flags are only driven while the link is down
   assign an_local_o = ~link_req_i & (aneg_i == 2'h1);
   assign an_remote_o = ~link_req_i & (aneg_i == 2'h2);
   assign an_unknown_o = ~link_req_i & (aneg_i == 2'h3);
endmodule : fsli_phy_model
`default_nettype wire

// *** testbench/tb.sv ***
// self-checking bench of the fieldbus status lamp block
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic clk_i, rst_n_i, rd, wr, wait_o, run, err, flt, irq;
   logic [4:0] addr;
   logic [31:0] wdata, rdata, q;
   logic [1:0] lreq, traf, lamp, lnk, act, anl, anr, anu;
   logic [1:0] an [2];
   logic [3:0] rot;
   logic [7:0] code;
   int n_mismatch = 0;
   int checks = 0;
   // ---------------------------------------------------------------
   // clock, design and port models
   // ---------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   fsli_top #(.TICK_CYC(4)) uut (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(addr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_byteenable_i(4'hF),
      .avs_writedata_i(wdata), .avs_readdata_o(rdata),
      .avs_waitrequest_o(wait_o),
      .upstream_port_link_i(lnk[0]), .upstream_port_act_i(act[0]),
      .upstream_port_aneg_local_i(anl[0]),
      .upstream_port_aneg_remote_i(anr[0]),
      .upstream_port_aneg_unknown_i(anu[0]),
      .downstream_port_link_i(lnk[1]), .downstream_port_act_i(act[1]),
      .downstream_port_aneg_local_i(anl[1]),
      .downstream_port_aneg_remote_i(anr[1]),
      .downstream_port_aneg_unknown_i(anu[1]),
      .rotary_switch_i(rot), .port_link_activity_lamp_o(lamp),
      .run_lamp_o(run), .error_lamp_o(err), .fieldbus_fault_o(flt),
      .fieldbus_fault_display_code_o(code), .irq_o(irq));
   for (genvar g = 0; g < 2; g++) begin : g_phy
      fsli_phy_model phy (.clk_i(clk_i), .link_req_i(lreq[g]),
         .traffic_i(traf[g]), .aneg_i(an[g]), .link_o(lnk[g]),
         .act_o(act[g]), .an_local_o(anl[g]), .an_remote_o(anr[g]),
         .an_unknown_o(anu[g]));
   end
   // ---------------------------------------------------------------
   // checking and bus tasks
   // ---------------------------------------------------------------
   task automatic end_sim();
      $display("mismatches %0d, checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_sim
   task automatic cmp(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp
   function automatic logic lamp_of(input int sel);
      logic [3:0] v;
      v = {err, run, lamp};
      return v[sel];
   endfunction : lamp_of
   // lit cycles and edges over one 160 cycle frame, phase independent
   task automatic cmp_lamp(input string nm, input int sel,
                           input fsli_pkg::fsli_pat_t p);
      logic prev, cur;
      logic [7:0] lit, tog;
      logic [15:0] e;
      repeat (20) @(posedge clk_i);
      @(negedge clk_i);
      prev = lamp_of(sel);
      lit = 8'h00;
      tog = 8'h00;
      repeat (160) begin
         @(negedge clk_i);
         cur = lamp_of(sel);
         lit += {7'h00, cur};
         tog += {7'h00, cur ^ prev};
         prev = cur;
      end
      case (p)
         fsli_pkg::PAT_OFF: e = 16'h0000;
         fsli_pkg::PAT_ON: e = 16'hA000;
         fsli_pkg::PAT_FLICK: e = 16'h5028;
         fsli_pkg::PAT_BLINK: e = 16'h500A;
         fsli_pkg::PAT_SINGLE: e = 16'h1002;
         fsli_pkg::PAT_DOUBLE: e = 16'h2004;
         fsli_pkg::PAT_TRIPLE: e = 16'h3006;
         default: e = 16'h8004;
      endcase
      cmp({nm, " lit"}, {24'h0, e[15:8]}, {24'h0, lit});
      cmp({nm, " edges"}, {24'h0, e[7:0]}, {24'h0, tog});
   endtask : cmp_lamp
   task automatic bus(input logic w, input logic [4:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      int n;
      @(posedge clk_i);
      rd <= ~w;
      wr <= w;
      addr <= a;
      wdata <= d;
      for (n = 0; n < 50; n++) begin
         @(posedge clk_i);
         if (wait_o === 1'b0) break;
      end
      if (n == 50) begin
         n_mismatch++;
         end_sim();
      end
      r = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus
   task automatic wr32(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask : wr32
   task automatic rd32(input logic [4:0] a, output logic [31:0] r);
      bus(1'b0, a, 32'h0, r);
   endtask : rd32
   task automatic setp(input int p, input logic l, input logic t,
                       input logic [1:0] a);
      @(posedge clk_i);
      lreq[p] <= l;
      traf[p] <= t;
      an[p] <= a;
   endtask : setp
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      rd32(fsli_pkg::OFS_CTRL, q);
      cmp("ctrl reset", {28'h0, fsli_pkg::CTRL_RST}, q);
      rd32(fsli_pkg::OFS_ROT, q);
      cmp("rotary booting", 32'h0, q);
      rd32(fsli_pkg::OFS_STAT, q);
      cmp("stat booting", 32'h1 << fsli_pkg::STAT_BOOT, q & 32'h6F);
      cmp_lamp("run booting", 2, fsli_pkg::PAT_FLICK);
      cmp_lamp("err reset", 3, fsli_pkg::PAT_OFF);
      cmp("fault reset", 32'h0, {31'h0, flt});
   endtask : t_reset
   task automatic t_port(input int p);
      setp(p, 1'b1, 1'b0, 2'h0);
      cmp_lamp("port on", p, fsli_pkg::PAT_ON);
      setp(p, 1'b1, 1'b1, 2'h0);
      cmp_lamp("port traffic", p, fsli_pkg::PAT_FLICK);
      setp(p, 1'b0, 1'b0, 2'h0);
      cmp_lamp("port down", p, fsli_pkg::PAT_OFF);
      for (int k = 1; k < 4; k++) begin
         setp(p, 1'b0, 1'b0, 2'(k));
         cmp_lamp("port aneg", p, fsli_pkg::fsli_pat_t'(8'h08 << k));
      end
      wr32(fsli_pkg::OFS_CTRL, 32'h0);
      cmp_lamp("port aneg plain", p, fsli_pkg::PAT_OFF);
      wr32(fsli_pkg::OFS_CTRL, 32'h2);
      setp(p, 1'b1, 1'b0, 2'h0);
      wr32(fsli_pkg::OFS_HOLD, 32'h1 << p);
      cmp_lamp("port held", p, fsli_pkg::PAT_INVDBL);
      wr32(fsli_pkg::OFS_HOLD, 32'h0);
   endtask : t_port
   task automatic t_run();
      logic [3:0] st [5];
      fsli_pkg::fsli_pat_t pt [5];
      st = '{fsli_pkg::AL_INIT, fsli_pkg::AL_PREOP, fsli_pkg::AL_SAFEOP,
             fsli_pkg::AL_OP, fsli_pkg::AL_BOOT};
      pt = '{fsli_pkg::PAT_OFF, fsli_pkg::PAT_BLINK, fsli_pkg::PAT_SINGLE,
             fsli_pkg::PAT_ON, fsli_pkg::PAT_FLICK};
      for (int i = 0; i < 5; i++) begin
         wr32(fsli_pkg::OFS_AL, {28'h0, st[i]});
         cmp_lamp("run state", 2, pt[i]);
      end
      wr32(fsli_pkg::OFS_CTRL, 32'h6);
      cmp_lamp("run identify", 2, fsli_pkg::PAT_TRIPLE);
      wr32(fsli_pkg::OFS_CTRL, 32'h2);
   endtask : t_run
   task automatic t_rot();
      wr32(fsli_pkg::OFS_AL, {28'h0, fsli_pkg::AL_INIT});
      rd32(fsli_pkg::OFS_ROT, q);
      cmp("rotary init", 32'hA, q);
      wr32(fsli_pkg::OFS_AL, {28'h0, fsli_pkg::AL_OP});
      rd32(fsli_pkg::OFS_ROT, q);
      cmp("rotary op", 32'h0, q);
      rd32(5'h02, q);
      cmp("unaligned read", 32'h0, q);
   endtask : t_rot
   task automatic t_err();
      wr32(fsli_pkg::OFS_ERRC, 32'h1);
      repeat (3) @(negedge clk_i);
      cmp("fault", 32'h1, {31'h0, flt});
      cmp("fault code", {24'h0, fsli_pkg::FAULT_CODE}, {24'h0, code});
      cmp_lamp("err unused", 3, fsli_pkg::PAT_OFF);
      wr32(fsli_pkg::OFS_CTRL, 32'h3);
      cmp_lamp("err wdog", 3, fsli_pkg::PAT_DOUBLE);
      wr32(fsli_pkg::OFS_ERRC, 32'h2);
      cmp_lamp("err local", 3, fsli_pkg::PAT_SINGLE);
      wr32(fsli_pkg::OFS_ERRC, 32'h4);
      cmp_lamp("err config", 3, fsli_pkg::PAT_BLINK);
      wr32(fsli_pkg::OFS_AL, {28'h0, fsli_pkg::AL_INIT});
      wr32(fsli_pkg::OFS_ERRC, 32'h8);
      cmp_lamp("err boot", 3, fsli_pkg::PAT_FLICK);
      wr32(fsli_pkg::OFS_ERRC, 32'h0);
      cmp_lamp("err none", 3, fsli_pkg::PAT_OFF);
      cmp("fault cleared", 32'h0, {24'h0, code});
      wr32(fsli_pkg::OFS_CTRL, 32'h2);
   endtask : t_err
   task automatic t_irq();
      wr32(fsli_pkg::OFS_ISTAT, 32'hF);
      wr32(fsli_pkg::OFS_IMASK, 32'h1);
      @(negedge clk_i);
      cmp("irq idle", 32'h0, {31'h0, irq});
      setp(0, 1'b0, 1'b0, 2'h0);
      repeat (5) @(negedge clk_i);
      cmp("irq link", 32'h1, {31'h0, irq});
      rd32(fsli_pkg::OFS_ISTAT, q);
      cmp("istat link", 32'h1, q);
      wr32(fsli_pkg::OFS_ISTAT, 32'h1);
      @(negedge clk_i);
      cmp("irq cleared", 32'h0, {31'h0, irq});
      wr32(fsli_pkg::OFS_IMASK, 32'h0);
      setp(0, 1'b0, 1'b0, 2'h1);
      repeat (5) @(negedge clk_i);
      cmp("irq masked", 32'h0, {31'h0, irq});
      rd32(fsli_pkg::OFS_ISTAT, q);
      cmp("istat aneg", 32'h4, q);
   endtask : t_irq
   initial begin
      rst_n_i = 1'b0;
      {rd, wr, addr, wdata, lreq, traf, rot} = '0;
      an[0] = 2'h0;
      an[1] = 2'h0;
      rot = 4'hA;
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1'b1;
      t_reset();
      t_port(0);
      t_port(1);
      t_run();
      t_rot();
      t_err();
      t_irq();
      end_sim();
   end
endmodule : tb
`default_nettype wire
